// [include/ffw_pkg.sv]
package ffw_pkg;

  // Register indices (no offsets printed; byte address is index times four)
  localparam logic [7:0] IDX_S0_T76 = 8'h00;
  localparam logic [7:0] IDX_S0_T98 = 8'h01;
  localparam logic [7:0] IDX_S0_T10 = 8'h02;
  localparam logic [7:0] IDX_S1_T10 = 8'h03;
  localparam logic [7:0] IDX_S1_T32 = 8'h04;
  localparam logic [7:0] IDX_S1_T54 = 8'h05;
  localparam logic [7:0] IDX_S1_T76 = 8'h06;
  localparam logic [7:0] IDX_S1_T98 = 8'h07;
  localparam logic [7:0] IDX_S1_TAP10 = 8'h08;
  localparam logic [7:0] IDX_WIN_GEOM = 8'h09;

  // Field positions
  localparam int TAP_W = 12;
  localparam int TAP_ODD_LSB = 16;
  localparam int TAP_EVEN_LSB = 0;
  localparam int WIN_H_LSB = 24;
  localparam int WIN_W_LSB = 13;
  localparam int WIN_VC_LSB = 6;
  localparam int WIN_HC_LSB = 0;
  localparam int WIN_CODE_W = 7;
  localparam int WIN_HC_W = 6;

  // Writable masks; everything else reads zero
  localparam logic [31:0] TAP_PAIR_MASK = 32'h0fff_0fff;
  localparam logic [31:0] TAP_SOLO_MASK = 32'h0000_0fff;
  localparam logic [31:0] WIN_MASK = 32'h7f0f_ffff;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Decoded window geometry, in pixels or windows
  typedef struct packed {
    logic [8:0] height_px;
    logic [8:0] width_px;
    logic [7:0] vert_count;
    logic [6:0] horz_count;
    logic width_too_small;
    logic horz_count_bad;
  } ffw_geom_t;

  localparam logic [8:0] MIN_WIDTH_PX = 9'h008;
  localparam logic [5:0] HC_CODE_MAX = 6'h23;
  localparam logic [5:0] HC_CODE_MIN = 6'h01;

endpackage

// [hw/ffw_reg_cell.sv]
`timescale 1ns/1ps
// One masked 32-bit configuration register
module ffw_reg_cell #(
  parameter logic [31:0] MASK = 32'hffff_ffff
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] value
);
  logic [31:0] value_r;
  logic [31:0] value_nxt;

  // Reserved bits never store, so they read zero
  always_comb begin
    value_nxt = value_r;
    if (wr_en) begin
      value_nxt = wdata & MASK;
    end
  end

  // Clears to zero at reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= ffw_pkg::REG_RESET;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;
endmodule // ffw_reg_cell

// [hw/ffw_regs.sv]
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module ffw_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic [11:0] set0_tap [0:10],
  output logic [11:0] set1_tap [0:10],
  output logic [6:0] window_height_code,
  output logic [6:0] window_width_code,
  output logic [6:0] vertical_window_count,
  output logic [5:0] horizontal_window_count,
  output ffw_pkg::ffw_geom_t geom,
  output logic [4:0] sum_integer_part
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // Index field must fit the ten-register map
  initial begin
    if (ADDR_W < 6) begin
      $error("ffw_regs: ADDR_W too small");
    end
    // Word index is held in eight bits, so wider buses would be cut
    if (ADDR_W > 10) begin
      $error("ffw_regs: ADDR_W too large");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_s1_r; // First stage, read only by second
  logic rst_s2_r; // Synchronised reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam int NREG = 10;
  logic [NREG-1:0] wr_sel; // One-hot write enable
  logic [7:0] idx; // Word index from byte address
  logic hit; // Address maps to a register

  // Byte address to word index; low two bits ignored
  always_comb begin
    idx = 8'h00;
    idx[ADDR_W-3:0] = addr[ADDR_W-1:2];
    hit = (idx <= ffw_pkg::IDX_WIN_GEOM);
    wr_sel = '0;
    if (wr_stb && hit) begin
      wr_sel[idx[3:0]] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register cells

  logic [31:0] val [0:NREG-1]; // Stored register contents

  // All ten cells: pair and solo registers of both sets, and the window register
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_cell
      localparam logic [31:0] CMASK =
        (gi == 9) ? ffw_pkg::WIN_MASK :
        ((gi == 2) || (gi == 8)) ? ffw_pkg::TAP_SOLO_MASK : ffw_pkg::TAP_PAIR_MASK;
      ffw_reg_cell #(.MASK(CMASK)) u_cell (
        .mclk(mclk),
        .rst_n(rst_s2_r),
        .wr_en(wr_sel[gi]),
        .wdata(wdata),
        .value(val[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Set 0 taps 0..5 live outside this bank; only 6..10 are stored here

  // Unpack tap fields for the filter datapath
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      set0_tap[i] = 12'h000;
      set1_tap[i] = 12'h000;
    end
    set0_tap[6] = val[0][11:0];
    set0_tap[7] = val[0][27:16];
    set0_tap[8] = val[1][11:0];
    set0_tap[9] = val[1][27:16];
    set0_tap[10] = val[2][11:0];
    for (int i = 0; i < 5; i++) begin
      set1_tap[2*i] = val[3+i][11:0];
      set1_tap[2*i+1] = val[3+i][27:16];
    end
    set1_tap[10] = val[8][11:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-point view

  // Integer part of set 1 tap 10, top bits of the signed tap: five integer bits, seven fraction
  logic signed [11:0] tap_s; // Signed view of one tap
  always_comb begin
    tap_s = signed'(set1_tap[10]);
    sum_integer_part = tap_s[11:7];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window geometry

  // Field extraction and pixel decode
  always_comb begin
    window_height_code = val[9][30:24];
    window_width_code = val[9][19:13];
    vertical_window_count = val[9][12:6];
    horizontal_window_count = val[9][5:0];
    geom.height_px = ({2'b00, window_height_code} + 9'h001) << 1;
    geom.width_px = ({2'b00, window_width_code} + 9'h001) << 1;
    geom.vert_count = {1'b0, vertical_window_count} + 8'h01;
    geom.horz_count = {1'b0, horizontal_window_count} + 7'h01;
    // Flags only; software owns legality, hardware does not clamp
    geom.width_too_small = (geom.width_px < ffw_pkg::MIN_WIDTH_PX);
    geom.horz_count_bad = (horizontal_window_count > ffw_pkg::HC_CODE_MAX) ||
                          (horizontal_window_count < ffw_pkg::HC_CODE_MIN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rdata_r; // Read data, valid cycle after strobe
  logic [31:0] rdata_nxt;

  // Unmapped reads return zero; data stands only one cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_stb) begin
      rdata_nxt = hit ? val[idx[3:0]] : ffw_pkg::UNMAPPED_DATA;
    end
  end

  // Registered read data
  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

endmodule // ffw_regs

// [bench/ffw_regs_chk.sv]
`timescale 1ns/1ps
// Watches the register port and the decoded window outputs
module ffw_regs_chk #(parameter int ADDR_W = 8) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [11:0] set1_tap [0:10],
  input wire logic [6:0] window_height_code,
  input wire logic [6:0] window_width_code,
  input wire logic [6:0] vertical_window_count,
  input wire logic [5:0] horizontal_window_count,
  input wire ffw_pkg::ffw_geom_t geom
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  property p_pair_wr;
    wr_stb && addr[7:2] == 6'h03 |=>
      set1_tap[1] == $past(wdata[27:16]) && set1_tap[0] == $past(wdata[11:0]);
  endproperty
  a_pair_wr: assert property (p_pair_wr) else $error("pair write misplaced");
  property p_pair_rd;
    rd_stb && addr[7:2] == 6'h03 |=>
      rdata == {4'h0, $past(set1_tap[1]), 4'h0, $past(set1_tap[0])};
  endproperty
  a_pair_rd: assert property (p_pair_rd) else $error("pair readback wrong");
  property p_solo;
    wr_stb && addr[7:2] == 6'h08 |=> set1_tap[10] == $past(wdata[11:0]);
  endproperty
  a_solo: assert property (p_solo) else $error("tap ten not stored");
  // Pixel sizes must follow the codes at once, with no lag
  property p_height;
    geom.height_px == {1'b0, window_height_code, 1'b0} + 9'h002;
  endproperty
  a_height: assert property (p_height) else $error("height pixels wrong");
  property p_width;
    geom.width_px == {1'b0, window_width_code, 1'b0} + 9'h002
      && geom.width_too_small == (window_width_code < 7'h03);
  endproperty
  a_width: assert property (p_width) else $error("width pixels wrong");
  property p_win_wr;
    wr_stb && addr[7:2] == 6'h09 |=> {window_height_code, window_width_code,
      vertical_window_count, horizontal_window_count} == $past({wdata[30:24], wdata[19:0]});
  endproperty
  a_win_wr: assert property (p_win_wr) else $error("window fields wrong");
  property p_win_rd;
    rd_stb && addr[7:2] == 6'h09 |=> rdata == {1'b0, $past(window_height_code), 4'h0,
      $past(window_width_code), $past(vertical_window_count), $past(horizontal_window_count)};
  endproperty
  a_win_rd: assert property (p_win_rd) else $error("window readback wrong");
  cover property (wr_stb && addr[7:2] == 6'h09);
  cover property (geom.width_too_small);
  cover property (rd_stb ##1 rdata != 32'h0);
endmodule // ffw_regs_chk
bind ffw_regs ffw_regs_chk #(.ADDR_W(ADDR_W)) ffw_regs_chk_inst (.mclk, .nrst, .addr,
  .wdata, .wr_stb, .rd_stb, .rdata, .set1_tap, .window_height_code, .window_width_code,
  .vertical_window_count, .horizontal_window_count, .geom);

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic [11:0] t0 [0:10];
  logic [11:0] t1 [0:10];
  logic [6:0] hc, wc, vc;
  logic [5:0] nc;
  ffw_pkg::ffw_geom_t geom;
  logic [4:0] sip;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // Readback after the pattern write, per index; index 10 is unmapped
  logic [31:0] rows [0:10] = '{32'h0abc0ef1, 32'h0abc0ef1, 32'h00000ef1, 32'h0abc0ef1,
    32'h0abc0ef1, 32'h0abc0ef1, 32'h0abc0ef1, 32'h0abc0ef1, 32'h00000ef1, 32'h1a0cdef1, 32'h0};
  ffw_regs ffw_regs_inst (.mclk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .set0_tap(t0), .set1_tap(t1), .window_height_code(hc), .window_width_code(wc),
    .vertical_window_count(vc), .horizontal_window_count(nc), .geom, .sum_integer_part(sip));
  initial forever #20 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write; the trailing delay lets the new value settle
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    @(posedge mclk);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    @(posedge mclk);
    addr <= {idx, 2'b00};
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far above the fewer than a hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(6'h09, 32'h0);
    for (int i = 0; i < 11; i++) wr(6'(i), 32'h9abcdef1);
    for (int i = 0; i < 11; i++) rd(6'(i), rows[i]);
    check(32'(t0[10]), 32'hef1);
    check(32'(sip), 32'h1d);
    check(32'(geom.height_px), 32'h036);
    check(32'(geom.width_px), 32'h0ce);
    // Too-small width of 6 pixels, top vertical count, horizontal code edges
    wr(6'h09, 32'h00005fc1);
    check(32'({geom.width_too_small, geom.horz_count_bad, geom.vert_count}), 32'h280);
    check(32'(geom.horz_count), 32'h002);
    wr(6'h09, 32'h00000000);
    check(32'(geom.horz_count_bad), 32'h1);
    wr(6'h09, 32'h00000023);
    check(32'(geom.horz_count_bad), 32'h0);
    wr(6'h09, 32'h00000024);
    check(32'(geom.horz_count_bad), 32'h1);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    check(32'(nc), 32'h0);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(6'h03, 32'h0);
    finish_test();
  end
endmodule // tb_top
